// File: bhsc_defs.svh
/*
 Constants for the bus hold and snoop control block: address width,
 bus state encodings, fill sizes and stop-grant timing.
 Assumes inclusion by bare name from the block's design files.
*/
`ifndef BHSC_DEFS_SVH
`define BHSC_DEFS_SVH
`define BHSC_ADDR_W 32
`define BHSC_LINE_BEATS 4'h4
`define BHSC_LINE_LSB 4
`define BHSC_DRAIN_NS 100
`define BHSC_CLK_NS 25
`define BHSC_DRAIN_CYC ((`BHSC_DRAIN_NS + `BHSC_CLK_NS - 1) / `BHSC_CLK_NS)
`define BHSC_ST_IDLE 3'h0
`define BHSC_ST_ADDR 3'h1
`define BHSC_ST_DATA 3'h2
`define BHSC_ST_HOLD 3'h3
`define BHSC_ST_BUS_BACKOFF 3'h4
`endif

// File: bhsc_pkg.sv
/*
 Types shared by the bus hold and snoop control block.
 Assumes bhsc_defs.svh is compiled alongside.
*/
`include "bhsc_defs.svh"
package bhsc_pkg;
   typedef enum logic [2:0] {
      BHSC_IDLE = 3'h0,
      BHSC_ADDR = 3'h1,
      BHSC_DATA = 3'h2,
      BHSC_HOLD = 3'h3,
      BHSC_BUS_BACKOFF = 3'h4
   } bhsc_bus_t;
   typedef enum logic [1:0] {
      BHSC_RUN = 2'h0,
      BHSC_BOUNDARY = 2'h1,
      BHSC_DRAIN = 2'h2,
      BHSC_GRANT = 2'h3
   } bhsc_stop_t;
endpackage

// File: bhsc_stop_ctrl.sv
/*
 Clock-stop sequencer: waits for an instruction boundary, drains the
 pipelines and write buffers, then asks for one stop-grant bus cycle.
 Assumes the requester holds the stop request until the grant cycle runs.
*/
`timescale 1ns/1ps
`include "bhsc_defs.svh"
module bhsc_stop_ctrl (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_stop_req_n,
   input wire logic i_insn_boundary,
   input wire logic i_irq_pending,
   input wire logic i_buffers_empty,
   input wire logic i_grant_done,
   output logic o_halt,
   output logic o_grant_req
);
   bhsc_pkg::bhsc_stop_t st_q, st_d;
   logic [7:0] drain_q, drain_d;
   logic granted_q, granted_d;
   wire logic stop_seen = ~i_stop_req_n; // active low
   wire logic drained = i_buffers_empty && (drain_q == 8'h00);

   // Sequence; an interrupt at the boundary defers the halt
   always_comb begin
      st_d = st_q;
      drain_d = (drain_q != 8'h00) ? drain_q - 8'h01 : 8'h00;
      // Remembers the grant cycle ran, so a held request gets only one
      granted_d = (st_q == bhsc_pkg::BHSC_GRANT) && (granted_q || i_grant_done);
      case (st_q)
         bhsc_pkg::BHSC_RUN: if (stop_seen) st_d = bhsc_pkg::BHSC_BOUNDARY;
         bhsc_pkg::BHSC_BOUNDARY: if (i_insn_boundary && !i_irq_pending) begin
            st_d = bhsc_pkg::BHSC_DRAIN;
            drain_d = 8'(`BHSC_DRAIN_CYC);
         end
         bhsc_pkg::BHSC_DRAIN: if (drained) st_d = bhsc_pkg::BHSC_GRANT;
         bhsc_pkg::BHSC_GRANT: begin
            // Request is held until here, so release is safe afterwards
            if (granted_d && !stop_seen) st_d = bhsc_pkg::BHSC_RUN;
         end
         default: st_d = bhsc_pkg::BHSC_RUN;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= bhsc_pkg::BHSC_RUN;
         drain_q <= 8'h00;
         granted_q <= 1'b0;
         o_halt <= 1'b0;
         o_grant_req <= 1'b0;
      end else begin
         st_q <= st_d;
         drain_q <= drain_d;
         granted_q <= granted_d;
         o_halt <= (st_d == bhsc_pkg::BHSC_DRAIN) || (st_d == bhsc_pkg::BHSC_GRANT);
         o_grant_req <= (st_d == bhsc_pkg::BHSC_GRANT) && !granted_d;
      end
   end
endmodule // bhsc_stop_ctrl

// File: bhsc_bus_ctrl.sv
/*
 Bus ownership and snoop control: hold and acknowledge, backoff with
 cycle restart, address float, snoop invalidate and line-fill gating.
 Assumes all pins are synchronous to I_CLOCK; the stop request is
 treated as synchronous too.
*/
// Functional notes
// - On stop request, halt at a boundary, drain buffers, run stop-grant cycle.
// - Bus demand output driven whenever bus is needed, never floated.
// - Hold request: finish cycle, burst or lock, then float and acknowledge.
// - Stay surrendered while hold request remains asserted.
// - Acknowledge rises with the float, stays, drops on leaving.
// - Backoff floats the hold pins next clock, without acknowledge.
// - Backoff wins over ready in the same clock.
// - Stay floated during backoff; interrupted cycle restarts from start.
// - Address float request floats only the address bus next clock.
// - Sampled snoop strobe invalidates the matching cache line.
// - Fill enable one clock before first ready makes a line fill.
// - Fill enable one clock before last ready writes line to cache.
// - Polarities: hold, ack, demand, addr float, stop grant high; others low.
`timescale 1ns/1ps
`include "bhsc_defs.svh"
module bhsc_bus_ctrl (
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire logic I_HOLD_REQ,
   input wire logic I_BUS_BACKOFF_N,
   input wire logic I_ADDRESS_FLOAT_REQUEST,
   input wire logic I_SNOOP_ADDRESS_STROBE_N,
   input wire logic I_CACHEABLE_FILL_ENABLE_N,
   input wire logic I_CYCLE_READY_N,
   input wire logic I_BURST_READY_N,
   input wire logic I_CLOCK_STOP_REQUEST_N,
   input wire logic [31:0] I_ADDR,
   input wire logic I_CORE_REQ,
   input wire logic I_CORE_WRITE,
   input wire logic I_CORE_CACHEABLE,
   input wire logic I_CORE_LOCK,
   input wire logic [31:0] I_CORE_ADDR,
   input wire logic I_INSN_BOUNDARY,
   input wire logic I_IRQ_PENDING,
   input wire logic I_BUFFERS_EMPTY,
   output logic [31:0] O_ADDR,
   output logic O_ADDR_OE,
   output logic O_CTRL_OE,
   output logic O_ADDR_STROBE_N,
   output logic O_STOP_GRANT,
   output logic O_INTERNAL_BUS_DEMAND,
   output logic O_BUS_SURRENDER_ACK,
   output logic O_CYCLE_DONE,
   output logic O_LINE_FILL,
   output logic O_CACHE_WRITE,
   output logic O_SNOOP_INVALIDATE,
   output logic [27:0] O_SNOOP_LINE,
   output logic O_HALT
);
   bhsc_pkg::bhsc_bus_t st_q, st_d;
   logic [31:0] cyc_addr_q;
   logic cyc_write_q, cyc_cache_q, cyc_grant_q, fill_q, ken_prev_q, first_q;
   logic [3:0] beat_q;
   logic halt_w, grant_req_w;

   // Polarity decode of the sampled pins
   wire logic backoff = ~I_BUS_BACKOFF_N;
   wire logic rdy = ~I_CYCLE_READY_N;
   wire logic burst_ready = ~I_BURST_READY_N;
   wire logic ken = ~I_CACHEABLE_FILL_ENABLE_N;
   wire logic snoop = ~I_SNOOP_ADDRESS_STROBE_N;
   // Backoff masks ready so no data is taken in that clock
   wire logic ready = (rdy || burst_ready) && !backoff;
   // A fill is decided on the first beat, so that beat must not end the burst
   wire logic fill_now = (beat_q == 4'h0) && cyc_cache_q && !cyc_write_q && ken_prev_q;
   wire logic last_beat = !(fill_q || fill_now) || rdy || (beat_q == `BHSC_LINE_BEATS - 4'h1);
   wire logic done = (st_q == bhsc_pkg::BHSC_DATA) && ready && last_beat;
   wire logic want = I_CORE_REQ || grant_req_w;
   // Locked sequences keep the bus until the core drops its lock
   wire logic may_hold = I_HOLD_REQ && !I_CORE_LOCK;
   wire logic floated = (st_d == bhsc_pkg::BHSC_HOLD) || (st_d == bhsc_pkg::BHSC_BUS_BACKOFF);

   bhsc_stop_ctrl u_stop (
      .i_clk(I_CLOCK),
      .i_rst(I_SYS_RST),
      .i_stop_req_n(I_CLOCK_STOP_REQUEST_N),
      .i_insn_boundary(I_INSN_BOUNDARY),
      .i_irq_pending(I_IRQ_PENDING),
      .i_buffers_empty(I_BUFFERS_EMPTY),
      .i_grant_done(done && cyc_grant_q),
      .o_halt(halt_w),
      .o_grant_req(grant_req_w)
   );

   // Bus state; backoff beats everything except a granted hold, hold waits for cycle end
   always_comb begin
      st_d = st_q;
      case (st_q)
         bhsc_pkg::BHSC_IDLE: begin
            if (backoff) st_d = bhsc_pkg::BHSC_BUS_BACKOFF;
            else if (may_hold) st_d = bhsc_pkg::BHSC_HOLD;
            else if (want) st_d = bhsc_pkg::BHSC_ADDR;
         end
         bhsc_pkg::BHSC_ADDR: st_d = backoff ? bhsc_pkg::BHSC_BUS_BACKOFF : bhsc_pkg::BHSC_DATA;
         bhsc_pkg::BHSC_DATA: begin
            if (backoff) st_d = bhsc_pkg::BHSC_BUS_BACKOFF;
            else if (done) st_d = may_hold ? bhsc_pkg::BHSC_HOLD : bhsc_pkg::BHSC_IDLE;
         end
         bhsc_pkg::BHSC_HOLD: if (!I_HOLD_REQ) st_d = bhsc_pkg::BHSC_IDLE;
         bhsc_pkg::BHSC_BUS_BACKOFF: begin
            // Restart the pending cycle from its address phase
            if (!backoff) st_d = first_q ? bhsc_pkg::BHSC_IDLE : bhsc_pkg::BHSC_ADDR;
         end
         default: st_d = bhsc_pkg::BHSC_IDLE;
      endcase
   end

   // State and cycle bookkeeping
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         st_q <= bhsc_pkg::BHSC_IDLE;
         cyc_addr_q <= 32'h00000000;
         {cyc_write_q, cyc_cache_q, cyc_grant_q, fill_q, ken_prev_q} <= 5'h00;
         first_q <= 1'b1;
         beat_q <= 4'h0;
      end else begin
         st_q <= st_d;
         ken_prev_q <= ken; // Fill enable is judged one clock before ready
         if (st_q == bhsc_pkg::BHSC_IDLE && st_d == bhsc_pkg::BHSC_ADDR) begin
            cyc_addr_q <= I_CORE_ADDR;
            cyc_write_q <= I_CORE_WRITE && !grant_req_w;
            cyc_cache_q <= I_CORE_CACHEABLE && !grant_req_w;
            cyc_grant_q <= grant_req_w;
            first_q <= 1'b0;
         end
         if (st_d == bhsc_pkg::BHSC_ADDR) begin
            beat_q <= 4'h0; // Restart also rewinds the fill
            fill_q <= 1'b0;
         end else if (st_q == bhsc_pkg::BHSC_DATA && ready) begin
            beat_q <= beat_q + 4'h1;
            if (beat_q == 4'h0 && cyc_cache_q && !cyc_write_q && ken_prev_q)
               fill_q <= 1'b1;
         end
         if (done) first_q <= 1'b1;
      end
   end

   // Registered pins; acknowledge and float move together
   always_ff @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         O_ADDR <= 32'h00000000;
         {O_ADDR_OE, O_CTRL_OE, O_STOP_GRANT, O_BUS_SURRENDER_ACK} <= 4'h0;
         O_ADDR_STROBE_N <= 1'b1;
         O_INTERNAL_BUS_DEMAND <= 1'b0;
         {O_CYCLE_DONE, O_LINE_FILL, O_CACHE_WRITE, O_SNOOP_INVALIDATE} <= 4'h0;
         O_SNOOP_LINE <= 28'h0000000;
         O_HALT <= 1'b0;
      end else begin
         O_ADDR <= (st_d == bhsc_pkg::BHSC_ADDR && st_q == bhsc_pkg::BHSC_IDLE) ?
                   I_CORE_ADDR : cyc_addr_q;
         O_CTRL_OE <= !floated;
         // Address float leaves the rest of the bus driven
         O_ADDR_OE <= !floated && !I_ADDRESS_FLOAT_REQUEST;
         O_ADDR_STROBE_N <= !(st_d == bhsc_pkg::BHSC_ADDR);
         O_STOP_GRANT <= (st_d != bhsc_pkg::BHSC_IDLE) && (st_d != bhsc_pkg::BHSC_HOLD) &&
                         (st_q == bhsc_pkg::BHSC_IDLE ? grant_req_w : cyc_grant_q);
         O_BUS_SURRENDER_ACK <= (st_d == bhsc_pkg::BHSC_HOLD);
         // Demand is a pure level, never floated, even while held off
         O_INTERNAL_BUS_DEMAND <= want || (st_d == bhsc_pkg::BHSC_BUS_BACKOFF && !first_q);
         O_CYCLE_DONE <= done;
         O_LINE_FILL <= fill_q || (st_q == bhsc_pkg::BHSC_DATA && ready &&
                        beat_q == 4'h0 && cyc_cache_q && !cyc_write_q && ken_prev_q);
         O_CACHE_WRITE <= done && fill_q && ken_prev_q;
         // Address pins carry the snooped address when strobed
         O_SNOOP_INVALIDATE <= snoop;
         if (snoop) O_SNOOP_LINE <= I_ADDR[31:`BHSC_LINE_LSB];
         O_HALT <= halt_w;
      end
   end
endmodule // bhsc_bus_ctrl

// File: bhsc_checker_assertions.sv
/* Port timing checker for bhsc_bus_ctrl.
 Assumes a bind to the design top and one clock domain. */
`timescale 1ns/1ps
module bhsc_checker (
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire logic I_HOLD_REQ,
   input wire logic I_BUS_BACKOFF_N,
   input wire logic I_ADDRESS_FLOAT_REQUEST,
   input wire logic I_SNOOP_ADDRESS_STROBE_N,
   input wire logic I_CYCLE_READY_N,
   input wire logic I_BURST_READY_N,
   input wire logic I_CORE_REQ,
   input wire logic [31:0] I_ADDR,
   input wire logic O_ADDR_OE,
   input wire logic O_CTRL_OE,
   input wire logic O_INTERNAL_BUS_DEMAND,
   input wire logic O_BUS_SURRENDER_ACK,
   input wire logic O_CYCLE_DONE,
   input wire logic O_SNOOP_INVALIDATE,
   input wire logic [27:0] O_SNOOP_LINE
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   // Ack and float move together; only a hold may raise the ack
   a_ack_on_hold: assert property (
      $rose(O_BUS_SURRENDER_ACK) |-> $past(I_HOLD_REQ) && !O_CTRL_OE && !O_ADDR_OE)
      else $error("ack rose badly");
   a_ack_kept: assert property (
      O_BUS_SURRENDER_ACK && I_HOLD_REQ && I_BUS_BACKOFF_N |=> O_BUS_SURRENDER_ACK)
      else $error("ack dropped early");
   a_ack_freed: assert property (
      O_BUS_SURRENDER_ACK && !I_HOLD_REQ |=> !O_BUS_SURRENDER_ACK)
      else $error("ack held late");
   // Backoff floats next clock without ack and beats any ready
   a_bus_backoff_float: assert property (
      !I_BUS_BACKOFF_N && !O_BUS_SURRENDER_ACK |=> !O_CTRL_OE && !O_BUS_SURRENDER_ACK)
      else $error("backoff float");
   a_bus_backoff_ready: assert property (
      O_CYCLE_DONE |-> $past(I_BUS_BACKOFF_N)
         && !($past(I_BURST_READY_N) && $past(I_CYCLE_READY_N)))
      else $error("done without ready");
   a_addr_float: assert property (
      I_ADDRESS_FLOAT_REQUEST |=> !O_ADDR_OE)
      else $error("address still driven");
   a_snoop_line: assert property (
      !I_SNOOP_ADDRESS_STROBE_N |=> O_SNOOP_INVALIDATE && O_SNOOP_LINE == $past(I_ADDR[31:4]))
      else $error("snoop line wrong");
   a_demand_on: assert property (
      I_CORE_REQ && !O_CYCLE_DONE |=> O_INTERNAL_BUS_DEMAND || O_CYCLE_DONE)
      else $error("demand missing");
endmodule // bhsc_checker

// File: bhsc_partner.sv
/* System controller model: ready per transfer and fill enable.
 Assumes it sees the design strobe, control enable and done. */
`timescale 1ns/1ps
module bhsc_partner (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_strobe_n,
   input wire logic i_oe,
   input wire logic i_done,
   input wire logic [3:0] i_wait,
   input wire logic i_ken_n,
   input wire logic i_use_rdy,
   output logic o_ken_n,
   output logic o_cycle_ready_n,
   output logic o_burst_ready_n
);
   logic busy_q = 1'b0;
   logic [3:0] cnt_q = 4'h0;
   wire rdy = busy_q && cnt_q == 4'h0;
   // Falling edge moves, so a restarted cycle reloads the wait
   always @(negedge i_clk) begin
      if (i_rst || i_done) busy_q <= 1'b0;
      else if (!i_strobe_n && i_oe) begin
         busy_q <= 1'b1;
         cnt_q <= i_wait;
      end else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   end
   // Ready held each beat; pulled-up lines idle high
   assign o_burst_ready_n = !(rdy && !i_use_rdy);
   assign o_cycle_ready_n = !(rdy && i_use_rdy);
   assign o_ken_n = busy_q ? i_ken_n : 1'b1;
endmodule // bhsc_partner

// File: bus_hold_snoop_control_bench.sv
/* Self-checking bench for bhsc_bus_ctrl with the controller model.
 Assumes a 40 MHz clock; inputs move on the falling edge. */
`timescale 1ns/1ps
module bus_hold_snoop_control_bench;
   logic clk = 0, rst = 1, hold = 0, bus_backoff_n = 1, afl = 0, snoop_address_strobe_n = 1, stp_n = 1;
   logic req = 0, cach = 0, kn = 1, urdy = 0, irq = 0, lck = 0, fill_s, wr_s;
   logic [31:0] addr = '0, caddr = '0, oad;
   logic [27:0] line;
   logic [3:0] wt = '0;
   logic aoe, coe, as_n, sg, dem, ack, done, fill, cwr, inv, halt, ken_n, rdy_n, burst_ready_n;
   int err_total = 0, n_compared = 0, n;
   // Rows: wait, cacheable, fill enable, then expected fill and write
   logic [7:0] rows [4] = '{8'h04, 8'h2B, 8'h1C, 8'h30};
   initial forever #12.5 clk = ~clk;
   bhsc_bus_ctrl bhsc_bus_ctrl_inst (.I_CLOCK(clk), .I_SYS_RST(rst), .I_HOLD_REQ(hold),
      .I_BUS_BACKOFF_N(bus_backoff_n), .I_ADDRESS_FLOAT_REQUEST(afl), .I_SNOOP_ADDRESS_STROBE_N(snoop_address_strobe_n),
      .I_CACHEABLE_FILL_ENABLE_N(ken_n), .I_CYCLE_READY_N(rdy_n), .I_BURST_READY_N(burst_ready_n),
      .I_CLOCK_STOP_REQUEST_N(stp_n), .I_ADDR(addr), .I_CORE_REQ(req), .I_CORE_WRITE(1'b0),
      .I_CORE_CACHEABLE(cach), .I_CORE_LOCK(lck), .I_CORE_ADDR(caddr), .I_INSN_BOUNDARY(1'b1),
      .I_IRQ_PENDING(irq), .I_BUFFERS_EMPTY(1'b1), .O_ADDR(oad), .O_ADDR_OE(aoe),
      .O_CTRL_OE(coe), .O_ADDR_STROBE_N(as_n), .O_STOP_GRANT(sg), .O_INTERNAL_BUS_DEMAND(dem),
      .O_BUS_SURRENDER_ACK(ack), .O_CYCLE_DONE(done), .O_LINE_FILL(fill), .O_CACHE_WRITE(cwr),
      .O_SNOOP_INVALIDATE(inv), .O_SNOOP_LINE(line), .O_HALT(halt));
   bhsc_partner bhsc_partner_inst (.i_clk(clk), .i_rst(rst), .i_strobe_n(as_n), .i_oe(coe),
      .i_done(done), .i_wait(wt), .i_ken_n(kn), .i_use_rdy(urdy), .o_ken_n(ken_n),
      .o_cycle_ready_n(rdy_n), .o_burst_ready_n(burst_ready_n));
   task chk(input logic [35:0] g, input logic [35:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Bounded wait for done; the request drops once it is seen
   task fin;
      n = 0;
      fill_s = 0;
      wr_s = 0;
      while (done !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
         fill_s |= fill;
         wr_s |= cwr;
      end
      chk(done, 1);
      req = 0;
   endtask
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog well past the hundred or so cycles the tests need
   initial begin
      #20000;
      err_total++;
      give_verdict;
   end
   initial begin
      repeat (2) @(negedge clk);
      chk({ack, coe, aoe, as_n}, 4'h1);
      rst = 0;
      @(negedge clk);
      foreach (rows[i]) begin
         {wt, cach, kn} = rows[i][7:2];
         urdy = !rows[i][3];
         caddr = {rows[i], 24'h5A5A50};
         req = 1;
         @(negedge clk);
         chk({dem, as_n, oad}, {2'b10, caddr});
         fin;
         @(negedge clk);
         wr_s |= cwr;
         chk({fill_s, wr_s}, rows[i][1:0]);
         $display("row %0d done", i);
      end
      // Hold beats a pending core request; ack tracks the float
      hold = 1;
      req = 1;
      @(negedge clk);
      chk({ack, coe, aoe}, 3'h4);
      repeat (3) @(negedge clk);
      chk({ack, dem, coe}, 3'h6);
      hold = 0;
      @(negedge clk);
      chk(ack, 0);
      fin;
      $display("hold test done");
      // Backoff lands with ready in the data clock, then restarts
      wt = 0;
      urdy = 1;
      cach = 0;
      req = 1;
      repeat (2) @(negedge clk);
      bus_backoff_n = 0;
      repeat (3) begin
         @(negedge clk);
         chk({coe, ack, done}, 3'h0);
      end
      bus_backoff_n = 1;
      n = 0;
      while (as_n !== 1'b0 && n < 4) begin
         @(negedge clk);
         n++;
      end
      chk(as_n, 0);
      fin;
      $display("backoff test done");
      // Snoop under address float; control pins stay driven
      afl = 1;
      @(negedge clk);
      chk({aoe, coe}, 2'h1);
      addr = 32'h1234_5670;
      snoop_address_strobe_n = 0;
      @(negedge clk);
      snoop_address_strobe_n = 1;
      afl = 0;
      addr = ~addr;
      chk({inv, line}, {1'b1, 28'h1234567});
      $display("snoop test done");
      // Stop request held until the grant cycle has run; a pending interrupt defers it
      stp_n = 0;
      irq = 1;
      repeat (4) @(negedge clk);
      chk({sg, halt}, 2'h0);
      irq = 0;
      n = 0;
      while (sg !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk({sg, halt}, 2'h3);
      fin;
      stp_n = 1;
      repeat (3) @(negedge clk);
      chk({sg, as_n, halt}, 3'h2);
      $display("stop test done");
      // Hold in mid-cycle waits for the cycle end, then a locked core defers it
      wt = 2;
      req = 1;
      @(negedge clk);
      hold = 1;
      @(negedge clk);
      chk({ack, coe}, 2'h1);
      fin;
      chk({ack, coe}, 2'h2);
      hold = 0;
      @(negedge clk);
      lck = 1;
      hold = 1;
      repeat (2) @(negedge clk);
      chk(ack, 0);
      lck = 0;
      @(negedge clk);
      chk(ack, 1);
      hold = 0;
      @(negedge clk);
      chk(ack, 0);
      $display("hold timing test done");
      // Reset in mid-cycle floats address and control, drops strobe and demand; requests resume next edge
      wt = 3;
      req = 1;
      @(negedge clk);
      rst = 1;
      @(negedge clk);
      chk({ack, coe, aoe, as_n, dem}, 5'h02);
      rst = 0;
      @(negedge clk);
      chk({coe, aoe, as_n, dem}, 4'hD);
      fin;
      $display("reset test done");
      give_verdict;
   end
endmodule // bus_hold_snoop_control_bench
bind bhsc_bus_ctrl bhsc_checker bhsc_checker_inst (.*);
